// File: hdl/dps_pkg.sv
package dps_pkg;
  localparam int REF_CLK_HZ = 20000000;
  localparam int REF_CLK_NS = 50;
  // Longest select low time, microseconds, for 85 C and 105 C
  localparam int MAX_SELECT_LOW_TIME_US_85 = 4;
  localparam int MAX_SELECT_LOW_TIME_US_105 = 1;
  localparam int MAX_SELECT_LOW_CYC_85 =
    (MAX_SELECT_LOW_TIME_US_85 * 1000) / REF_CLK_NS;
  localparam int MAX_SELECT_LOW_CYC_105 =
    (MAX_SELECT_LOW_TIME_US_105 * 1000) / REF_CLK_NS;
  // Least refresh time, ns, fast and slow speed grade
  localparam int REFRESH_TIME_MIN_NS_FAST = 35;
  localparam int REFRESH_TIME_MIN_NS_SLOW = 36;
  localparam int REFRESH_CYC_FAST =
    (REFRESH_TIME_MIN_NS_FAST + REF_CLK_NS - 1) / REF_CLK_NS;
  localparam int REFRESH_CYC_SLOW =
    (REFRESH_TIME_MIN_NS_SLOW + REF_CLK_NS - 1) / REF_CLK_NS;
  localparam int PHASE_SHIFT_DEG = 90;
  localparam int FIFO_DEPTH = 8;
  localparam int DATA_W = 8;
  localparam int LATENCY_CYC = 4;
  localparam int CLK_DIV = 2;
  localparam logic [7:0] MEM_RESET_VAL = 8'h00;
  typedef enum logic [2:0] {
    DPS_IDLE = 3'b000,
    DPS_CMD = 3'b001,
    DPS_LAT = 3'b010,
    DPS_READ = 3'b011,
    DPS_WRITE = 3'b100
  } dps_state_t;
endpackage : dps_pkg

// File: hdl/dps_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dps_if;
  logic select_n;
  logic bus_clk;
  logic bus_clk_comp;
  logic phase_shift_clk;
  logic phase_shift_clk_comp;
  logic [7:0] dq_h2d;
  logic dq_h2d_oe;
  logic [7:0] dq_d2h;
  logic dq_d2h_oe;
  logic strobe_h2d;
  logic strobe_h2d_oe;
  logic strobe_d2h;
  logic strobe_d2h_oe;
  logic mem_reset_n;
  modport device (
    input select_n, bus_clk, bus_clk_comp, phase_shift_clk,
    input phase_shift_clk_comp, dq_h2d, dq_h2d_oe, strobe_h2d,
    input strobe_h2d_oe, mem_reset_n,
    output dq_d2h, dq_d2h_oe, strobe_d2h, strobe_d2h_oe
  );
  modport host (
    output select_n, bus_clk, bus_clk_comp, phase_shift_clk,
    output phase_shift_clk_comp, dq_h2d, dq_h2d_oe, strobe_h2d,
    output strobe_h2d_oe, mem_reset_n,
    input dq_d2h, dq_d2h_oe, strobe_d2h, strobe_d2h_oe
  );
endinterface : dps_if
`default_nettype wire

// File: hdl/dps_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module dps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!reset_n || flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : dps_fifo
`default_nettype wire

// File: hdl/dps_device.sv
// Operation
// RULE1 - Select fall starts, rise ends transaction
// RULE2 - Host keeps select low under limit
// RULE3 - Host allows refresh time when latency flagged
// RULE4 - Strobe at start shows extra latency
// RULE5 - Strobe is byte mask during writes
// RULE6 - Read bytes aligned to strobe edges
// RULE7 - Host phase clock nominally ninety degrees late; host here lags half a bus clock period
// RULE8 - Phase clock ignored during writes
// RULE9 - Single-ended mode drives complementary phase low
// RULE10 - Differential mode uses both phase clocks
// RULE11 - Bus clock need not run freely
// RULE12 - Center-aligned strobing optional per variant
// RULE13 - Reset low idles, floats strobe and data
// RULE14 - Select rise anytime aborts to idle
`timescale 1ns/1ns
`default_nettype none
module dps_device #(
  parameter bit CENTER_ALIGNED = 1'b1,
  parameter bit DIFF_CLK = 1'b0,
  parameter int ADDR_W = 4
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  dps_if.device bus,
  output logic refresh_pending_q
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the bus clock may stop, so all timing is sampled
  logic [1:0] sel_s_q, clk_s_q, psc_s_q, pscc_s_q, rst_s_q;
  logic [1:0] stb_s_q;
  logic [7:0] dq_s1_q, dq_s2_q;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sel_s_q <= 2'h3;
      clk_s_q <= 2'h0;
      psc_s_q <= 2'h0;
      pscc_s_q <= 2'h0;
      rst_s_q <= 2'h0;
      stb_s_q <= 2'h0;
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
    end else begin
      sel_s_q <= {sel_s_q[0], bus.select_n};
      clk_s_q <= {clk_s_q[0], bus.bus_clk};
      psc_s_q <= {psc_s_q[0], bus.phase_shift_clk};
      pscc_s_q <= {pscc_s_q[0], bus.phase_shift_clk_comp};
      rst_s_q <= {rst_s_q[0], bus.mem_reset_n};
      stb_s_q <= {stb_s_q[0], bus.strobe_h2d};
      dq_s1_q <= bus.dq_h2d;
      dq_s2_q <= dq_s1_q;
    end
  end
  logic sel_n, mem_rst_n, psc_lvl;
  logic clk_prev_q, psc_prev_q, sel_prev_q;
  logic clk_edge, psc_edge, sel_fall, sel_rise;
  assign sel_n = sel_s_q[1];
  assign mem_rst_n = rst_s_q[1];
  // Differential pair: true high and complement low reads as high
  assign psc_lvl = DIFF_CLK ? (psc_s_q[1] && !pscc_s_q[1])
                            : psc_s_q[1]; // [RULE10] [RULE9]
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      clk_prev_q <= 1'b0;
      psc_prev_q <= 1'b0;
      sel_prev_q <= 1'b1;
    end else begin
      clk_prev_q <= clk_s_q[1];
      psc_prev_q <= psc_lvl;
      sel_prev_q <= sel_n;
    end
  end
  // Edges, not levels, drive the sequence so a stopped clock stalls it
  assign clk_edge = clk_s_q[1] != clk_prev_q; // [RULE11]
  assign psc_edge = psc_lvl != psc_prev_q;
  assign sel_fall = sel_prev_q && !sel_n; // [RULE1]
  assign sel_rise = !sel_prev_q && sel_n; // [RULE1] [RULE14]
  logic psc_edge_use;
  // Variants without the option time the strobe from the bus clock
  assign psc_edge_use = CENTER_ALIGNED ? psc_edge : clk_edge; // [RULE12]
  ////////////////////////////////////////////////////////////////////////
  // Memory array and transaction state
  logic [7:0] mem_q [2**ADDR_W];
  dps_pkg::dps_state_t st_q;
  logic [2:0] cnt_q;
  logic [ADDR_W-1:0] addr_q;
  logic is_read_q;
  logic extra_q;
  logic abort;
  assign abort = !mem_rst_n || sel_rise; // [RULE13] [RULE14]
  always_ff @(posedge ref_clk) begin
    if (!reset_n || abort) begin
      st_q <= dps_pkg::DPS_IDLE;
      cnt_q <= 3'h0;
      is_read_q <= 1'b0;
      extra_q <= 1'b0;
    end else begin
      case (st_q)
        dps_pkg::DPS_IDLE: begin
          if (sel_fall) begin
            st_q <= dps_pkg::DPS_CMD; // [RULE1]
            extra_q <= refresh_pending_q;
            cnt_q <= 3'h0;
          end
        end
        dps_pkg::DPS_CMD: begin
          if (clk_edge) begin
            if (cnt_q == 3'h0) begin
              is_read_q <= dq_s2_q[7];
              cnt_q <= 3'h1;
            end else begin
              st_q <= dps_pkg::DPS_LAT;
              cnt_q <= 3'h0;
            end
          end
        end
        dps_pkg::DPS_LAT: begin
          if (clk_edge) begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'(extra_q ? 2 * dps_pkg::LATENCY_CYC - 1
                                    : dps_pkg::LATENCY_CYC - 1)) begin
              st_q <= is_read_q ? dps_pkg::DPS_READ : dps_pkg::DPS_WRITE;
            end
          end
        end
        dps_pkg::DPS_READ: begin
        end
        dps_pkg::DPS_WRITE: begin
        end
        default: begin
          st_q <= dps_pkg::DPS_IDLE;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Refresh bookkeeping: owed during each transaction, and still owed after one shorter than REFRESH_CYC_SLOW cycles
  logic [15:0] low_cnt_q;
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !mem_rst_n) begin
      low_cnt_q <= 16'h0000;
      refresh_pending_q <= 1'b0;
    end else if (st_q == dps_pkg::DPS_IDLE) begin
      low_cnt_q <= 16'h0000;
      if (low_cnt_q >= 16'(dps_pkg::REFRESH_CYC_SLOW)) begin
        refresh_pending_q <= 1'b0;
      end
    end else begin
      low_cnt_q <= low_cnt_q + 16'h0001;
      refresh_pending_q <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Data path: address from command, writes masked, reads streamed
  always_ff @(posedge ref_clk) begin
    if (!reset_n || abort || st_q == dps_pkg::DPS_IDLE) begin
      addr_q <= '0;
    end else if (st_q == dps_pkg::DPS_CMD && clk_edge && cnt_q == 3'h1) begin
      addr_q <= dq_s2_q[ADDR_W-1:0];
    end else if ((st_q == dps_pkg::DPS_READ && psc_edge_use) ||
                 (st_q == dps_pkg::DPS_WRITE && clk_edge)) begin
      addr_q <= addr_q + 1'b1;
    end
  end
  // Array cleared by the logic reset only; the pin reset keeps contents
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < 2**ADDR_W; i++) begin
        mem_q[i] <= dps_pkg::MEM_RESET_VAL;
      end
    end else if (st_q == dps_pkg::DPS_WRITE && clk_edge && !stb_s_q[1]) begin
      mem_q[addr_q] <= dq_s2_q; // [RULE5] [RULE8]
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Pin drivers; all released in idle and under the memory reset
  always_ff @(posedge ref_clk) begin
    if (!reset_n || abort) begin
      bus.dq_d2h <= 8'h00;
      bus.dq_d2h_oe <= 1'b0; // [RULE13] [RULE14]
      bus.strobe_d2h <= 1'b0;
      bus.strobe_d2h_oe <= 1'b0;
    end else begin
      case (st_q)
        dps_pkg::DPS_CMD, dps_pkg::DPS_LAT: begin
          bus.strobe_d2h_oe <= 1'b1;
          bus.strobe_d2h <= extra_q; // [RULE4]
          bus.dq_d2h_oe <= 1'b0;
        end
        dps_pkg::DPS_READ: begin
          bus.strobe_d2h_oe <= 1'b1;
          bus.dq_d2h_oe <= 1'b1;
          if (psc_edge_use) begin
            bus.dq_d2h <= mem_q[addr_q];
            bus.strobe_d2h <= !bus.strobe_d2h; // [RULE6]
          end
        end
        default: begin
          bus.strobe_d2h_oe <= 1'b0; // [RULE5]
          bus.dq_d2h_oe <= 1'b0;
        end
      endcase
    end
  end
endmodule : dps_device
`default_nettype wire

// File: hdl/dps_host.sv
`timescale 1ns/1ns
`default_nettype none
module dps_host #(
  parameter int MAX_LOW_CYC = dps_pkg::MAX_SELECT_LOW_CYC_105,
  parameter bit DIFF_CLK = 1'b0
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic req_valid,
  output logic req_ready_q,
  input wire logic req_read,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  dps_if.host bus
);
  logic [1:0] stb_s_q, oe_s_q;
  logic [7:0] dq_s1_q, dq_s2_q;
  logic stb_prev_q;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stb_s_q <= 2'h0;
      oe_s_q <= 2'h0;
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
      stb_prev_q <= 1'b0;
    end else begin
      stb_s_q <= {stb_s_q[0], bus.strobe_d2h};
      oe_s_q <= {oe_s_q[0], bus.strobe_d2h_oe};
      dq_s1_q <= bus.dq_d2h;
      dq_s2_q <= dq_s1_q;
      stb_prev_q <= stb_s_q[1];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Sequencer: select low, two command beats, wait, one data beat
  logic [15:0] t_q;
  logic fifo_in_ready;
  logic push_q;
  logic rd_q;
  logic ext_q;
  logic [7:0] addr_q;
  logic [7:0] wdata_q;
  dps_pkg::dps_state_t st_q;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_q <= dps_pkg::DPS_IDLE;
      t_q <= 16'h0000;
      push_q <= 1'b0;
      req_ready_q <= 1'b0;
      rd_q <= 1'b0;
      ext_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      bus.select_n <= 1'b1;
      bus.bus_clk <= 1'b0;
      bus.phase_shift_clk <= 1'b0;
      bus.dq_h2d <= 8'h00;
      bus.dq_h2d_oe <= 1'b0;
      bus.strobe_h2d <= 1'b0;
      bus.strobe_h2d_oe <= 1'b0;
    end else begin
      push_q <= 1'b0;
      req_ready_q <= 1'b0;
      t_q <= t_q + 16'h0001;
      // Clock toggles only inside a transaction
      if (st_q != dps_pkg::DPS_IDLE && t_q[0]) begin
        bus.bus_clk <= !bus.bus_clk;
        // Copy of the bus clock half a period late, not the ninety degrees of RULE7; held low through a whole write
        bus.phase_shift_clk <= rd_q ? bus.bus_clk : 1'b0; // [RULE7] [RULE8]
      end
      // Select never stays low past the limit
      if (st_q != dps_pkg::DPS_IDLE && t_q >= 16'(MAX_LOW_CYC - 1)) begin
        st_q <= dps_pkg::DPS_IDLE; // [RULE2] [RULE14]
        bus.select_n <= 1'b1;
        bus.dq_h2d_oe <= 1'b0;
        bus.strobe_h2d_oe <= 1'b0;
        t_q <= 16'h0000;
      end else begin
        case (st_q)
          dps_pkg::DPS_IDLE: begin
            bus.bus_clk <= 1'b0;
            bus.phase_shift_clk <= 1'b0;
            // Gap covers the refresh time before the next select
            if (req_valid && fifo_in_ready &&
                t_q >= 16'(dps_pkg::REFRESH_CYC_SLOW + 2)) begin // [RULE3]
              bus.select_n <= 1'b0; // [RULE1]
              bus.dq_h2d <= {req_read, 7'h00};
              bus.dq_h2d_oe <= 1'b1;
              bus.strobe_h2d <= 1'b0;
              // Request is latched; the caller may move on at once
              rd_q <= req_read;
              addr_q <= req_addr;
              wdata_q <= req_wdata;
              req_ready_q <= 1'b1;
              st_q <= dps_pkg::DPS_CMD;
              t_q <= 16'h0000;
            end
          end
          dps_pkg::DPS_CMD: begin
            // Address stands across the second bus clock edge
            if (t_q == 16'h0002) begin
              bus.dq_h2d <= addr_q;
            end
            // Lines freed for reads long before the device drives them
            if (t_q == 16'h0005) begin
              bus.dq_h2d <= wdata_q;
              bus.dq_h2d_oe <= !rd_q;
              st_q <= dps_pkg::DPS_LAT;
            end
          end
          dps_pkg::DPS_LAT: begin
            if (t_q == 16'h0008) begin
              ext_q <= oe_s_q[1] && stb_s_q[1]; // [RULE4]
            end
            if (t_q == (ext_q ? 16'h0017 : 16'h000f)) begin
              st_q <= rd_q ? dps_pkg::DPS_READ : dps_pkg::DPS_WRITE;
              // First data edge has passed unmasked; mask all after it
              bus.strobe_h2d <= 1'b1; // [RULE5]
              bus.strobe_h2d_oe <= !rd_q;
            end
          end
          dps_pkg::DPS_READ: begin
            if (oe_s_q[1] && stb_s_q[1] != stb_prev_q) begin
              push_q <= 1'b1; // [RULE6]
              st_q <= dps_pkg::DPS_IDLE;
              bus.select_n <= 1'b1;
              t_q <= 16'h0000;
            end
          end
          default: begin
            if (t_q == (ext_q ? 16'h001b : 16'h0013)) begin
              st_q <= dps_pkg::DPS_IDLE;
              bus.select_n <= 1'b1;
              bus.dq_h2d_oe <= 1'b0;
              bus.strobe_h2d_oe <= 1'b0;
              t_q <= 16'h0000;
            end
          end
        endcase
      end
    end
  end
  assign bus.bus_clk_comp = DIFF_CLK ? !bus.bus_clk : 1'b0;
  assign bus.phase_shift_clk_comp = DIFF_CLK ? !bus.phase_shift_clk
                                             : 1'b0; // [RULE9] [RULE10]
  assign bus.mem_reset_n = reset_n;
  dps_fifo #(.WIDTH(dps_pkg::DATA_W), .DEPTH(dps_pkg::FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .flush(1'b0),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data(dq_s2_q),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );
endmodule : dps_host
`default_nettype wire

// File: sim/dps_properties.sv
`timescale 1ns/1ns
`default_nettype none
module dps_properties #(
  parameter int MAX_LOW_CYC = 80,
  parameter bit DIFF_CLK = 1'b0
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic select_n,
  input wire logic bus_clk,
  input wire logic phase_shift_clk,
  input wire logic phase_shift_clk_comp,
  input wire logic dq_h2d_oe,
  input wire logic dq_d2h_oe,
  input wire logic strobe_h2d_oe,
  input wire logic strobe_d2h_oe,
  input wire logic strobe_d2h
);
  logic [15:0] low_cnt_q;
  // A long select low run starves the device of refresh
  always_ff @(posedge ref_clk) begin
    if (!reset_n || select_n) begin
      low_cnt_q <= 16'h0000;
    end else begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_low_limit; low_cnt_q <= MAX_LOW_CYC; endproperty
  a_low_limit: assert property (p_low_limit)
    else $error("select held low too long");
  property p_gap; $rose(select_n) |-> select_n [*2]; endproperty
  a_gap: assert property (p_gap)
    else $error("select high gap too short");
  property p_flag; $fell(select_n) |-> ##[1:6] strobe_d2h_oe; endproperty
  a_flag: assert property (p_flag)
    else $error("latency flag not driven at start");
  property p_dq_clash; !(dq_h2d_oe && dq_d2h_oe); endproperty
  a_dq_clash: assert property (p_dq_clash)
    else $error("both ends drive data");
  property p_strobe_clash; !(strobe_h2d_oe && strobe_d2h_oe); endproperty
  a_strobe_clash: assert property (p_strobe_clash)
    else $error("both ends drive strobe");
  property p_read_align; dq_d2h_oe |-> strobe_d2h_oe; endproperty
  a_read_align: assert property (p_read_align)
    else $error("read data without strobe");
  property p_write_psc; strobe_h2d_oe |-> !phase_shift_clk; endproperty
  a_write_psc: assert property (p_write_psc)
    else $error("phase clock moves during write");
  property p_se_comp; !DIFF_CLK |-> !phase_shift_clk_comp; endproperty
  a_se_comp: assert property (p_se_comp)
    else $error("complementary phase clock not low");
  property p_psc_lag;
    (!select_n && !dq_h2d_oe && !strobe_h2d_oe) |->
      phase_shift_clk == $past(bus_clk, 2);
  endproperty
  a_psc_lag: assert property (p_psc_lag)
    else $error("phase clock is not a late copy of bus clock");
  property p_idle_clk; select_n [*3] |-> !bus_clk; endproperty
  a_idle_clk: assert property (p_idle_clk)
    else $error("bus clock runs while idle");
  property p_abort;
    $rose(select_n) |-> ##[0:5] (!dq_d2h_oe && !strobe_d2h_oe);
  endproperty
  a_abort: assert property (p_abort)
    else $error("device holds bus after select rise");
  c_read: cover property (dq_d2h_oe);
  c_write: cover property (strobe_h2d_oe);
  c_flag: cover property (strobe_d2h_oe && strobe_d2h && !dq_d2h_oe);
endmodule : dps_properties
`default_nettype wire

// File: sim/ddr_memory_port_phase_strobe_bench.sv
`timescale 1ns/1ns
`default_nettype none
module ddr_memory_port_phase_strobe_bench;
  localparam int LOW_CYC = dps_pkg::MAX_SELECT_LOW_CYC_85;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_read = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_wdata = 8'h00;
  logic rd_ready = 1'b0;
  logic req_ready_q;
  logic rd_valid;
  logic [7:0] rd_data;
  logic pend_q;
  logic pend2_q;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  dps_if u_dps_if ();
  dps_if u_dps_if2 ();
  dps_host #(.MAX_LOW_CYC(LOW_CYC), .DIFF_CLK(1'b0)) u_dps_host (
    .ref_clk(ref_clk), .reset_n(reset_n), .req_valid(req_valid),
    .req_ready_q(req_ready_q), .req_read(req_read), .req_addr(req_addr),
    .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .bus(u_dps_if.host));
  dps_device #(.CENTER_ALIGNED(1'b1), .DIFF_CLK(1'b0)) u_dps_device (
    .ref_clk(ref_clk), .reset_n(reset_n), .bus(u_dps_if.device),
    .refresh_pending_q(pend_q));
  // Second device faces the bench, which misbehaves as host on purpose
  dps_device #(.CENTER_ALIGNED(1'b0)) u_dps_device2 (
    .ref_clk(ref_clk), .reset_n(reset_n), .bus(u_dps_if2.device),
    .refresh_pending_q(pend2_q));
  dps_properties #(.MAX_LOW_CYC(LOW_CYC), .DIFF_CLK(1'b0)) u_dps_properties (
    .ref_clk(ref_clk), .reset_n(reset_n), .select_n(u_dps_if.select_n),
    .bus_clk(u_dps_if.bus_clk), .phase_shift_clk(u_dps_if.phase_shift_clk),
    .phase_shift_clk_comp(u_dps_if.phase_shift_clk_comp),
    .dq_h2d_oe(u_dps_if.dq_h2d_oe), .dq_d2h_oe(u_dps_if.dq_d2h_oe),
    .strobe_h2d_oe(u_dps_if.strobe_h2d_oe),
    .strobe_d2h_oe(u_dps_if.strobe_d2h_oe),
    .strobe_d2h(u_dps_if.strobe_d2h));
  ////////////////////////////////////////////////////////////////////////////
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1
  // Request stays up until the edge that sees req_ready_q high
  task automatic host_req(input logic rd, input logic [7:0] a,
                          input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_read <= rd;
    req_addr <= a;
    req_wdata <= d;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (req_ready_q !== 1'b1 && n < 400);
    chk1(req_ready_q, 1'b1);
    @(posedge ref_clk);
    req_valid <= 1'b0;
  endtask : host_req
  task automatic pop(input logic [7:0] e);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (rd_valid !== 1'b1 && n < 400);
    chk8(rd_data, e);
    @(posedge ref_clk);
    rd_ready <= 1'b1;
    @(posedge ref_clk);
    rd_ready <= 1'b0;
  endtask : pop
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    logic seen;
    logic [7:0] a;
    u_dps_if2.select_n = 1'b1;
    u_dps_if2.bus_clk = 1'b0;
    u_dps_if2.bus_clk_comp = 1'b0;
    u_dps_if2.phase_shift_clk = 1'b0;
    u_dps_if2.phase_shift_clk_comp = 1'b0;
    u_dps_if2.dq_h2d = 8'h00;
    u_dps_if2.dq_h2d_oe = 1'b0;
    u_dps_if2.strobe_h2d = 1'b0;
    u_dps_if2.strobe_h2d_oe = 1'b0;
    u_dps_if2.mem_reset_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (dps_pkg::REFRESH_CYC_SLOW + 2) @(posedge ref_clk);
    host_req(1'b1, 8'h03, 8'h00);
    pop(dps_pkg::MEM_RESET_VAL);
    for (i = 0; i < 4; i++) begin
      a = 8'(i * 5);
      host_req(1'b0, a, {a[3:0], ~a[3:0]});
    end
    for (i = 0; i < 4; i++) begin
      a = 8'(i * 5);
      host_req(1'b1, a, 8'h00);
      pop({a[3:0], ~a[3:0]});
    end
    // Fill the read buffer with no reader, then expect the host to hold off
    for (i = 0; i < 8; i++) begin
      host_req(1'b1, 8'((i % 4) * 5), 8'h00);
    end
    repeat (150) @(posedge ref_clk);
    req_valid <= 1'b1;
    seen = 1'b0;
    repeat (200) begin
      @(posedge ref_clk);
      #1;
      if (req_ready_q === 1'b1) seen = 1'b1;
    end
    chk1(seen, 1'b0);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    for (i = 0; i < 8; i++) begin
      a = 8'((i % 4) * 5);
      pop({a[3:0], ~a[3:0]});
    end
    // Bench host opens, aborts once the device has left the latency wait for the write phase, then resets mid command
    @(posedge ref_clk);
    u_dps_if2.select_n <= 1'b0;
    repeat (6) begin
      @(posedge ref_clk);
      u_dps_if2.bus_clk <= ~u_dps_if2.bus_clk;
    end
    #1;
    chk1(u_dps_if2.strobe_d2h_oe, 1'b1);
    chk1(pend2_q, 1'b1);
    @(posedge ref_clk);
    u_dps_if2.select_n <= 1'b1;
    u_dps_if2.bus_clk <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    chk1(u_dps_if2.strobe_d2h_oe | u_dps_if2.dq_d2h_oe, 1'b0);
    @(posedge ref_clk);
    u_dps_if2.select_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    chk1(u_dps_if2.strobe_d2h_oe, 1'b1);
    @(posedge ref_clk);
    u_dps_if2.mem_reset_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    chk1(u_dps_if2.strobe_d2h_oe | u_dps_if2.dq_d2h_oe, 1'b0);
    chk1(pend2_q, 1'b0);
    @(posedge ref_clk);
    u_dps_if2.mem_reset_n <= 1'b1;
    u_dps_if2.select_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    chk1(pend_q, 1'b0);
    end_of_test();
  end
endmodule : ddr_memory_port_phase_strobe_bench
`default_nettype wire
